/* File: design/scs_source_select.sv */
// Target source and sample pacing select, link receiver and pulse scaling
//
// Operation
// - Targets come from serial commands or the link, and a command switches the source.
// - With default settings the serial command source is active after reset.
// - A stored boot setting picks the source that is active after reset.
// - Serial mode paces samples from the internal clock, link mode from link frames.
// - Starting in link mode with no link signal raises a clock-loss error.
// - After clock loss, correct link frames resume link operation without a command.
// - In serial mode a trigger input starts a move at the next internal sample.
// - One encoder cycle is split into 8192 position counts.
// - Angles are carried as encoder counts, never degrees.
// - Motor type picks 1000 or 1500 cycles per turn, times the subdivision.
`timescale 1ns/1ps
module scs_source_select #(
  parameter int POS_BITS = scs_pkg::LINK_POS_BITS,
  parameter int DEPTH    = 16
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       link_clk,
  input  wire logic                       link_sync,
  input  wire logic                       link_dat1,
  input  wire logic                       link_dat2,
  input  wire logic                       boot_link,
  input  wire logic                       cmd_set_src,
  input  wire scs_pkg::scs_src_type       cmd_src,
  input  wire scs_pkg::scs_pos_type       cmd_target,
  input  wire logic                       trigger,
  input  wire logic                       motor_fine,
  output scs_pkg::scs_src_type            active_src,
  output logic                            clock_loss,
  output logic                            sample_tick,
  output scs_pkg::scs_pos_type            target,
  output logic                            move_start,
  output logic [31:0]                     pulses_per_rev
);

  function automatic logic [31:0] rev_pulses(input logic fine);
    rev_pulses = fine ? 32'(scs_pkg::CYCLES_FINE * scs_pkg::SUBDIV)
                      : 32'(scs_pkg::CYCLES_STD * scs_pkg::SUBDIV);
  endfunction : rev_pulses

  // Link domain: shift in 20-bit words per frame
  logic [scs_pkg::LINK_WORD_BITS-1:0] sh1;
  logic [scs_pkg::LINK_WORD_BITS-1:0] sh2;
  logic [scs_pkg::LINK_WORD_BITS-1:0] full1;
  logic [scs_pkg::LINK_WORD_BITS-1:0] full2;
  logic [4:0]                         bit_cnt;
  logic                               sync_d;
  scs_pkg::scs_pos_type               link_word;
  // No reset here: the link clock may be stopped while reset is high
  logic                               link_toggle = 1'b0;

  // Last bit is still on the pins at the frame-ending edge
  assign full1 = {sh1[scs_pkg::LINK_WORD_BITS-2:0], link_dat1};
  assign full2 = {sh2[scs_pkg::LINK_WORD_BITS-2:0], link_dat2};

  always_ff @(posedge link_clk) begin
    sync_d <= link_sync;
    sh1    <= {sh1[scs_pkg::LINK_WORD_BITS-2:0], link_dat1};
    sh2    <= {sh2[scs_pkg::LINK_WORD_BITS-2:0], link_dat2};
  end

  // Frame ends on falling sync; word is taken with the toggle
  always_ff @(posedge link_clk) begin
    if (sync_d && !link_sync) begin
      bit_cnt <= '0;
    end else if (bit_cnt != 5'h1f) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge link_clk) begin
    if (sync_d && !link_sync && bit_cnt == 5'(scs_pkg::LINK_WORD_BITS - 1)) begin
      link_word.axis1 <= POS_BITS'(full1 >> scs_pkg::LINK_POS_SHIFT);
      link_word.axis2 <= POS_BITS'(full2 >> scs_pkg::LINK_POS_SHIFT);
      link_toggle     <= ~link_toggle;
    end
  end

  // Crossing: toggle through two flops, word held stable
  logic                 tog_s1;
  logic                 tog_s2;
  logic                 tog_s3;
  logic                 frame_pulse;
  logic                 trig_s1;
  logic                 trig_s2;
  logic                 boot_s1;
  logic                 boot_s2;
  scs_pkg::scs_pos_type link_cap;

  // No reset: boot level must settle during reset, toggle must not fake an edge
  always_ff @(posedge clk) begin
    tog_s1  <= link_toggle;
    tog_s2  <= tog_s1;
    tog_s3  <= tog_s2;
    boot_s1 <= boot_link;
    boot_s2 <= boot_s1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
    end else begin
      trig_s1 <= trigger;
      trig_s2 <= trig_s1;
    end
  end

  assign frame_pulse = tog_s2 ^ tog_s3;

  // Word settled long before the toggle reaches the second flop
  always_ff @(posedge clk) begin
    if (frame_pulse) begin
      link_cap <= link_word;
    end
  end

  // Link frames go through the FIFO to the sample stage
  logic                 fifo_in_ready;
  logic                 fifo_valid;
  logic                 fifo_pop;
  scs_pkg::scs_pos_type fifo_data;
  logic                 frame_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      frame_q <= 1'b0;
    end else begin
      frame_q <= frame_pulse;
    end
  end

  scs_fifo #(
    .WIDTH ($bits(scs_pkg::scs_pos_type)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (frame_q),
    .in_ready  (fifo_in_ready),
    .in_data   (link_cap),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Boot strap caught after reset release
  logic boot_done;
  logic boot_sel;

  always_ff @(posedge clk) begin
    if (reset) begin
      boot_done <= 1'b0;
      boot_sel  <= scs_pkg::BOOT_LINK_DEFAULT;
    end else if (!boot_done) begin
      boot_done <= 1'b1;
      boot_sel  <= boot_s2;
    end
  end

  // Internal sample timer
  logic [$clog2(scs_pkg::SAMPLE_CYCLES)-1:0] int_cnt;
  logic                                      int_tick;

  assign int_tick = (int_cnt == '0);

  always_ff @(posedge clk) begin
    if (reset) begin
      int_cnt <= '0;
    end else if (int_tick) begin
      int_cnt <= ($clog2(scs_pkg::SAMPLE_CYCLES))'(scs_pkg::SAMPLE_CYCLES - 1);
    end else begin
      int_cnt <= int_cnt - 1'b1;
    end
  end

  // Clock loss watchdog and recovery
  logic [$clog2(scs_pkg::LOSS_CYCLES+1)-1:0] loss_cnt;
  logic [1:0]                                good_cnt;

  always_ff @(posedge clk) begin
    if (reset) begin
      loss_cnt <= '0;
    end else if (frame_pulse) begin
      loss_cnt <= '0;
    end else if (loss_cnt != ($clog2(scs_pkg::LOSS_CYCLES+1))'(scs_pkg::LOSS_CYCLES)) begin
      loss_cnt <= loss_cnt + 1'b1;
    end
  end

  // Set by silence wins over recovery count
  always_ff @(posedge clk) begin
    if (reset) begin
      clock_loss <= 1'b0;
      good_cnt   <= '0;
    end else if (!boot_done || active_src != scs_pkg::SRC_LINK) begin
      clock_loss <= 1'b0;
      good_cnt   <= '0;
    end else if (loss_cnt == ($clog2(scs_pkg::LOSS_CYCLES+1))'(scs_pkg::LOSS_CYCLES)) begin
      clock_loss <= 1'b1;
      good_cnt   <= '0;
    end else if (clock_loss && frame_pulse) begin
      if (good_cnt == 2'(scs_pkg::GOOD_FRAMES - 1)) begin
        clock_loss <= 1'b0;
        good_cnt   <= '0;
      end else begin
        good_cnt <= good_cnt + 2'h1;
      end
    end
  end

  // Source select; a command takes effect only at a sample boundary, the boot link select right after boot
  scs_pkg::scs_src_type pend_src;
  logic                 link_tick;

  assign link_tick   = fifo_valid && !clock_loss;
  assign sample_tick = (active_src == scs_pkg::SRC_LINK) ? link_tick : int_tick;
  assign fifo_pop    = fifo_valid && (active_src != scs_pkg::SRC_LINK || !clock_loss);

  always_ff @(posedge clk) begin
    if (reset) begin
      pend_src <= scs_pkg::SRC_SERIAL;
    end else if (!boot_done) begin
      pend_src <= boot_s2 ? scs_pkg::SRC_LINK : scs_pkg::SRC_SERIAL;
    end else if (cmd_set_src) begin
      pend_src <= cmd_src;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      active_src <= scs_pkg::SRC_SERIAL;
    end else if (boot_done && !$past(boot_done) && boot_sel) begin
      active_src <= scs_pkg::SRC_LINK;
    end else if (sample_tick || (active_src == scs_pkg::SRC_LINK && clock_loss && int_tick)) begin
      active_src <= pend_src;
    end
  end

  // Target register and triggered start
  logic trig_prev;
  logic trig_armed;

  always_ff @(posedge clk) begin
    if (reset) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_s2;
    end
  end

  // Edge armed now, start waits for next internal tick
  always_ff @(posedge clk) begin
    if (reset) begin
      trig_armed <= 1'b0;
      move_start <= 1'b0;
    end else begin
      move_start <= 1'b0;
      if (active_src != scs_pkg::SRC_SERIAL) begin
        trig_armed <= 1'b0;
      end else if (int_tick && (trig_armed || (trig_s2 && !trig_prev))) begin
        trig_armed <= 1'b0;
        move_start <= 1'b1;
      end else if (trig_s2 && !trig_prev) begin
        trig_armed <= 1'b1;
      end
    end
  end

  // Positions stay in encoder counts throughout
  always_ff @(posedge clk) begin
    if (reset) begin
      target <= '0;
    end else if (active_src == scs_pkg::SRC_LINK && link_tick) begin
      target <= fifo_data;
    end else if (active_src == scs_pkg::SRC_SERIAL && int_tick) begin
      target <= cmd_target;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pulses_per_rev <= rev_pulses(1'b0);
    end else begin
      pulses_per_rev <= rev_pulses(motor_fine);
    end
  end

  // Checks
  chk_default_serial: assert property (@(posedge clk) disable iff (reset)
    (!boot_done && !boot_s2) |=> ##1 active_src == scs_pkg::SRC_SERIAL)
    else $error("default boot not serial");

  chk_boot_link: assert property (@(posedge clk) disable iff (reset)
    (!boot_done && boot_s2) |=> ##1 active_src == scs_pkg::SRC_LINK)
    else $error("link boot setting ignored");

  chk_serial_pace: assert property (@(posedge clk) disable iff (reset)
    (active_src == scs_pkg::SRC_SERIAL) |-> sample_tick == int_tick)
    else $error("serial mode not paced internally");

  chk_loss_raise: assert property (@(posedge clk) disable iff (reset)
    (active_src == scs_pkg::SRC_LINK && boot_done && !frame_pulse && !clock_loss &&
     loss_cnt == ($clog2(scs_pkg::LOSS_CYCLES+1))'(scs_pkg::LOSS_CYCLES))
    |=> clock_loss)
    else $error("clock loss not raised");

  chk_loss_recover: assert property (@(posedge clk) disable iff (reset)
    (clock_loss && frame_pulse && good_cnt == 2'(scs_pkg::GOOD_FRAMES - 1) &&
     active_src == scs_pkg::SRC_LINK &&
     loss_cnt != ($clog2(scs_pkg::LOSS_CYCLES+1))'(scs_pkg::LOSS_CYCLES))
    |=> !clock_loss)
    else $error("no automatic recovery");

  chk_trig_delay: assert property (@(posedge clk) disable iff (reset)
    (active_src == scs_pkg::SRC_SERIAL && trig_s2 && !trig_prev && !cmd_set_src)
    |-> ##[1:101] move_start)
    else $error("trigger start late");

  chk_rev_count: assert property (@(posedge clk) disable iff (reset)
    ##1 pulses_per_rev == ($past(motor_fine) ? 32'h00bb_8000 : 32'h007d_0000))
    else $error("pulses per turn wrong");

  chk_switch_edge: assert property (@(posedge clk) disable iff (reset)
    (boot_done && $past(boot_done) && $past(boot_done, 2) && active_src != $past(active_src))
    |-> $past(sample_tick) || $past(int_tick))
    else $error("source changed off a sample boundary");

  chk_start_serial: assert property (@(posedge clk) disable iff (reset)
    move_start |-> $past(active_src) == scs_pkg::SRC_SERIAL)
    else $error("move started outside serial mode");

  chk_start_pulse: assert property (@(posedge clk) disable iff (reset)
    move_start |=> !move_start)
    else $error("move start longer than one cycle");

  cov_switch_link: cover property (@(posedge clk) disable iff (reset)
    $rose(active_src == scs_pkg::SRC_LINK));
  cov_loss: cover property (@(posedge clk) disable iff (reset) $rose(clock_loss));
  cov_recover: cover property (@(posedge clk) disable iff (reset) $fell(clock_loss));
  cov_trigger: cover property (@(posedge clk) disable iff (reset) move_start);

endmodule : scs_source_select

/* File: design/scs_pkg.sv */
// Shared constants and carrier types for the scan command source select block
package scs_pkg;

  // Control sample rate and link figures
  localparam int    CLK_HZ             = 10_000_000;
  localparam int    SAMPLE_HZ          = 100_000;
  localparam int    SAMPLE_CYCLES      = CLK_HZ / SAMPLE_HZ;
  localparam int    LINK_WORD_BITS     = 20;
  localparam int    LINK_POS_BITS      = 16;
  localparam int    LINK_POS_SHIFT     = 1;
  // Link is lost when no frame for this long
  localparam int    LOSS_TIME_US       = 20;
  localparam int    LOSS_CYCLES        = (LOSS_TIME_US * (CLK_HZ / 1_000_000));
  // Good frames needed before link use resumes
  localparam int    GOOD_FRAMES        = 2;

  // Encoder scaling
  localparam int    SUBDIV             = 8192;
  localparam int    CYCLES_STD         = 1000;
  localparam int    CYCLES_FINE        = 1500;

  // Power-on default source: serial text commands
  localparam logic  BOOT_LINK_DEFAULT  = 1'b0;

  typedef enum logic {
    SRC_SERIAL,
    SRC_LINK
  } scs_src_type;

  typedef struct packed {
    logic [LINK_POS_BITS-1:0] axis1;
    logic [LINK_POS_BITS-1:0] axis2;
  } scs_pos_type;

endpackage : scs_pkg

/* File: design/scs_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module scs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : scs_fifo

/* File: verif/scs_link_model.sv */
// Behavioural far-end scan controller driving the position link
`timescale 1ns/1ps
module scs_link_model (
  input  wire logic                 run,
  input  wire scs_pkg::scs_pos_type pos,
  output logic                      link_clk,
  output logic                      link_sync,
  output logic                      link_dat1,
  output logic                      link_dat2
);
  logic [19:0] word1, word2;

  // Frames go out whenever run is high, from time zero on
  initial begin
    link_clk  = 1'h0;
    link_sync = 1'h0;
    link_dat1 = 1'h0;
    link_dat2 = 1'h1;
    #3;
    forever begin
      if (run) begin
        // Position sits in bits 16..1
        word1 = {3'h1, pos.axis1, 1'h0};
        word2 = {3'h1, pos.axis2, 1'h0};
        // Sync low on the last bit marks the frame end
        for (int i = 19; i >= 0; i--) begin
          link_sync = (i != 0);
          link_dat1 = word1[i];
          link_dat2 = word2[i];
          #7.5 link_clk = 1'h1;
          #7.5 link_clk = 1'h0;
        end
        // Released data must not look like a held bit
        link_dat1 = ~link_dat1;
        link_dat2 = ~link_dat2;
        #9700;
      end else begin
        #100;
      end
    end
  end
endmodule : scs_link_model

/* File: verif/scan_command_source_select_test.sv */
// Self-checking bench for source select, clock loss, trigger and pulse scaling
`timescale 1ns/1ps
module scan_command_source_select_test;
  logic clk = 1'h0, reset = 1'h1, run = 1'h0;
  logic link_clk, link_sync, link_dat1, link_dat2, clock_loss, sample_tick, move_start;
  logic boot_link = 1'h0, cmd_set_src = 1'h0, trigger = 1'h0, motor_fine = 1'h0;
  scs_pkg::scs_src_type cmd_src = scs_pkg::SRC_SERIAL, active_src;
  scs_pkg::scs_pos_type cmd_target = '0, pos = '0, target;
  logic [31:0] pulses_per_rev, exp;
  int err_count = 0, num_checks = 0, starts = 0, n;

  always #50 clk = ~clk;
  always @(posedge clk) if (move_start === 1'h1) starts++;

  scs_link_model i_link (.run(run), .pos(pos), .link_clk(link_clk), .link_sync(link_sync),
    .link_dat1(link_dat1), .link_dat2(link_dat2));

  scs_source_select i_dut (.clk(clk), .reset(reset), .link_clk(link_clk),
    .link_sync(link_sync), .link_dat1(link_dat1), .link_dat2(link_dat2),
    .boot_link(boot_link), .cmd_set_src(cmd_set_src), .cmd_src(cmd_src),
    .cmd_target(cmd_target), .trigger(trigger), .motor_fine(motor_fine),
    .active_src(active_src), .clock_loss(clock_loss), .sample_tick(sample_tick),
    .target(target), .move_start(move_start), .pulses_per_rev(pulses_per_rev));

  task automatic check_bit(input string name, input logic e, input logic got);
    num_checks++;
    if (got !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, e, got);
    end
  endtask : check_bit

  task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] got);
    num_checks++;
    if (got !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, e, got);
    end
  endtask : check_word

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // Tick is combinational, so it is looked at on the falling edge
  task automatic wait_tick(output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (sample_tick !== 1'h1 && cnt < 300);
  endtask : wait_tick

  task automatic do_reset(input logic boot);
    @(posedge clk);
    #1 boot_link = boot;
    reset = 1'h1;
    repeat (6) @(posedge clk);
    #1 reset = 1'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask : do_reset

  // Command issued just after a tick, so the next boundary is a full sample away
  task automatic set_src(input scs_pkg::scs_src_type s);
    wait_tick(n);
    @(posedge clk);
    #1 cmd_src = s;
    cmd_set_src = 1'h1;
    @(posedge clk);
    #1 cmd_set_src = 1'h0;
    repeat (40) @(posedge clk);
    #1 check_bit("src held", ~s, active_src);
    repeat (80) @(posedge clk);
    #1 check_bit("src new", s, active_src);
  endtask : set_src

  task automatic serial_target(input logic [31:0] v);
    cmd_target = scs_pkg::scs_pos_type'(v);
    wait_tick(n);
    @(posedge clk);
    #1 check_word("serial target", v, target);
  endtask : serial_target

  initial begin
    void'($urandom(98));
    do_reset(1'h0);
    check_bit("boot src", scs_pkg::SRC_SERIAL, active_src);
    check_bit("boot loss", 1'h0, clock_loss);
    for (int f = 1; f >= 0; f--) begin
      motor_fine = f[0];
      exp = (f == 1) ? scs_pkg::CYCLES_FINE * scs_pkg::SUBDIV
                     : scs_pkg::CYCLES_STD * scs_pkg::SUBDIV;
      repeat (3) @(posedge clk);
      #1 check_word("per rev", exp, pulses_per_rev);
    end
    $display("test scaling done");
    for (int i = 0; i < 4; i++) begin
      serial_target((i == 0) ? 32'hffff_0000 : $urandom);
      if (i > 0) check_word("serial gap", scs_pkg::SAMPLE_CYCLES, n);
    end
    check_bit("serial loss", 1'h0, clock_loss);
    $display("test serial done");
    for (int i = 0; i < 3; i++) begin
      repeat ($urandom_range(5, 40)) @(posedge clk);
      #1 trigger = 1'h1;
      n = 0;
      while (move_start !== 1'h1 && n < 120) begin
        @(negedge clk);
        n++;
      end
      check_bit("trig delay", 1'h1, n >= 4 && n <= 104);
      @(negedge clk);
      check_bit("start pulse", 1'h0, move_start);
      @(posedge clk);
      #1 trigger = 1'h0;
    end
    $display("test trigger done");
    pos = scs_pkg::scs_pos_type'($urandom);
    run = 1'h1;
    repeat (300) @(posedge clk);
    set_src(scs_pkg::SRC_LINK);
    repeat (250) @(posedge clk);
    #1 check_word("link target", pos, target);
    wait_tick(n);
    wait_tick(n);
    check_bit("link gap", 1'h1, n >= 99 && n <= 101);
    n = starts;
    @(posedge clk);
    #1 trigger = 1'h1;
    repeat (150) @(posedge clk);
    #1 trigger = 1'h0;
    check_word("link starts", n, starts);
    $display("test link done");
    run = 1'h0;
    n = 0;
    while (clock_loss !== 1'h1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check_bit("loss delay", 1'h1, n >= 90 && n <= 210);
    pos = scs_pkg::scs_pos_type'($urandom);
    run = 1'h1;
    repeat (500) @(posedge clk);
    #1 check_bit("recovered", 1'h0, clock_loss);
    check_bit("recover src", scs_pkg::SRC_LINK, active_src);
    check_word("recover target", pos, target);
    set_src(scs_pkg::SRC_SERIAL);
    serial_target($urandom);
    $display("test loss done");
    run = 1'h0;
    do_reset(1'h1);
    check_bit("link boot src", scs_pkg::SRC_LINK, active_src);
    repeat (300) @(posedge clk);
    #1 check_bit("boot loss", 1'h1, clock_loss);
    run = 1'h1;
    repeat (500) @(posedge clk);
    #1 check_bit("boot recover", 1'h0, clock_loss);
    check_word("boot target", pos, target);
    $display("test boot done");
    results();
  end

  // Tests need under 4000 cycles; the 10000-cycle limit is two and a half times that
  initial begin
    #1_000_000;
    err_count++;
    results();
  end
endmodule : scan_command_source_select_test
